// ==== rtl/dsim_pkg.sv ====
// Package with constants and types for the DMA/SCSI interrupt merge block.
package dsim_pkg;
  // DMA command bit positions.
  localparam int unsigned DSIM_CMD_PAGE_IE_BIT = 5;
  localparam int unsigned DSIM_CMD_XFER_IE_BIT = 6;
  localparam int unsigned DSIM_CMD_WIDTH = 8;
  // DMA status bit positions.
  localparam int unsigned DSIM_ST_POWER_DOWN_INPUT_BIT = 0;
  localparam int unsigned DSIM_ST_ABORT_BIT = 1;
  localparam int unsigned DSIM_ST_DONE_BIT = 2;
  localparam int unsigned DSIM_ST_ADDR_ERR_BIT = 3;
  localparam int unsigned DSIM_ST_SCSI_BIT = 4;
  localparam int unsigned DSIM_ST_PAGE_BIT = 5;
  localparam int unsigned DSIM_ST_WIDTH = 8;
  localparam logic [7:0] DSIM_ST_RESET = 8'h00;
  // Number of SCSI registers that must be read to clear a SCSI interrupt.
  localparam int unsigned DSIM_SCSI_READS = 3;
  localparam logic [2:0] DSIM_SCSI_ALL_READ = 3'h7;

  // DMA engine event pulses.
  typedef struct packed {
    logic done;
    logic addr_err;
    logic abort_cmd;
    logic master_abort;
    logic target_abort;
    logic page_done;
  } dsim_dma_ev_t;

  // SCSI block event pulses.
  typedef struct packed {
    logic bus_reset;
    logic illegal_cmd;
    logic disconnect;
    logic service_req;
    logic cmd_done;
    logic reselected;
  } dsim_scsi_ev_t;

  // Host read strobes of the SCSI registers.
  typedef struct packed {
    logic status_rd;
    logic state_rd;
    logic intr_rd;
  } dsim_scsi_rd_t;
endpackage

// ==== rtl/dsim_sticky.sv ====
// Sticky flag with set-wins-over-clear.
`timescale 1ns/1ps
`default_nettype none
module dsim_sticky (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Control.
  input wire logic set,
  input wire logic clr,
  // Flag.
  output logic flag
);
  // A set arriving during the clear cycle must not be lost, so set has priority.
  always_ff @(posedge mclk) begin
    if (rst) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule // dsim_sticky
`default_nettype wire

// ==== rtl/dsim_scsi_pend.sv ====
// SCSI-block interrupt pending tracker cleared after three register reads.
`timescale 1ns/1ps
`default_nettype none
module dsim_scsi_pend
  import dsim_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // SCSI events and host reads.
  input wire dsim_scsi_ev_t ev,
  input wire dsim_scsi_rd_t rd,
  // Pending state.
  output logic pending,
  output logic [2:0] reads_seen
);
  logic any_ev;
  logic [2:0] next_reads_seen;

  // Any documented SCSI cause raises the interrupt.
  assign any_ev = |ev;

  // Collect which of the three registers were read since the interrupt.
  always_comb begin
    next_reads_seen = reads_seen | {rd.status_rd, rd.state_rd, rd.intr_rd};
  end

  // Reads are only collected while pending; a new event restarts collection.
  always_ff @(posedge mclk) begin
    if (rst) begin
      reads_seen <= 3'h0;
    end else if (any_ev || !pending || next_reads_seen == DSIM_SCSI_ALL_READ) begin
      reads_seen <= 3'h0;
    end else begin
      reads_seen <= next_reads_seen;
    end
  end

  // Pending stays until all three reads are done; a fresh event wins.
  always_ff @(posedge mclk) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (any_ev) begin
      pending <= 1'b1;
    end else if (pending && next_reads_seen == DSIM_SCSI_ALL_READ) begin
      pending <= 1'b0;
    end
  end
endmodule // dsim_scsi_pend
`default_nettype wire

// ==== rtl/dsim_merge.sv ====
// Top of the DMA and SCSI interrupt merge block.
`timescale 1ns/1ps
`default_nettype none
module dsim_merge
  import dsim_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // DMA command register contents.
  input wire logic [7:0] dma_cmd,
  input wire logic descriptor_list_mode,
  // DMA engine events.
  input wire dsim_dma_ev_t dma_ev,
  // Power-down pin.
  input wire logic power_down_input,
  // SCSI block events and register reads.
  input wire dsim_scsi_ev_t scsi_ev,
  input wire dsim_scsi_rd_t scsi_rd,
  // Host read strobe of the DMA status register.
  input wire logic dma_status_rd,
  // Status and interrupt outputs.
  output logic [7:0] dma_status,
  output logic scsi_block_irq_flag,
  output logic irq
);
  logic xfer_ie;
  logic page_ie;
  logic power_down_input_q;
  logic power_down_input_rise;
  logic done_flag;
  logic addr_err_flag;
  logic abort_flag;
  logic page_flag;
  logic power_down_input_irq;
  logic scsi_pending;
  logic any_abort;
  logic [7:0] next_dma_status;

  // Enables from the DMA command register.
  assign xfer_ie = dma_cmd[DSIM_CMD_XFER_IE_BIT];
  assign page_ie = dma_cmd[DSIM_CMD_PAGE_IE_BIT];
  assign any_abort = dma_ev.abort_cmd | dma_ev.master_abort | dma_ev.target_abort;

  // Power-down edge detector; the pin is taken as synchronous.
  always_ff @(posedge mclk) begin
    if (rst) begin
      power_down_input_q <= 1'b0;
    end else begin
      power_down_input_q <= power_down_input;
    end
  end
  assign power_down_input_rise = power_down_input & ~power_down_input_q;

  // Completion is only latched with the transfer enable set.
  dsim_sticky u_done (
    .mclk(mclk),
    .rst(rst),
    .set(dma_ev.done & xfer_ie),
    .clr(dma_status_rd),
    .flag(done_flag)
  );

  // Address errors share the transfer enable.
  dsim_sticky u_addr_err (
    .mclk(mclk),
    .rst(rst),
    .set(dma_ev.addr_err & xfer_ie),
    .clr(dma_status_rd),
    .flag(addr_err_flag)
  );

  // Aborts need no enable.
  dsim_sticky u_abort (
    .mclk(mclk),
    .rst(rst),
    .set(any_abort),
    .clr(dma_status_rd),
    .flag(abort_flag)
  );

  // Page completion counts only in descriptor-list mode.
  dsim_sticky u_page (
    .mclk(mclk),
    .rst(rst),
    .set(dma_ev.page_done & descriptor_list_mode & page_ie),
    .clr(dma_status_rd),
    .flag(page_flag)
  );

  // Power-down interrupt latch, separate from the mirrored status bit.
  dsim_sticky u_power_down_input (
    .mclk(mclk),
    .rst(rst),
    .set(power_down_input_rise),
    .clr(dma_status_rd),
    .flag(power_down_input_irq)
  );

  // SCSI block pending state, untouched by DMA status reads.
  dsim_scsi_pend u_scsi (
    .mclk(mclk),
    .rst(rst),
    .ev(scsi_ev),
    .rd(scsi_rd),
    .pending(scsi_pending),
    .reads_seen()
  );
  assign scsi_block_irq_flag = scsi_pending;

  // Status image: one bit per cause; bit 0 follows the pin, not the latch.
  always_comb begin
    next_dma_status = DSIM_ST_RESET;
    next_dma_status[DSIM_ST_POWER_DOWN_INPUT_BIT] = power_down_input;
    next_dma_status[DSIM_ST_ABORT_BIT] = abort_flag;
    next_dma_status[DSIM_ST_DONE_BIT] = done_flag;
    next_dma_status[DSIM_ST_ADDR_ERR_BIT] = addr_err_flag;
    next_dma_status[DSIM_ST_SCSI_BIT] = scsi_pending;
    next_dma_status[DSIM_ST_PAGE_BIT] = page_flag;
  end

  // Registered status so the data output comes from flip-flops.
  always_ff @(posedge mclk) begin
    if (rst) begin
      dma_status <= DSIM_ST_RESET;
    end else begin
      dma_status <= next_dma_status;
    end
  end

  // DMA, power-down and SCSI sources drive the line; it drops when all are clear.
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= done_flag | addr_err_flag | abort_flag | page_flag | power_down_input_irq
             | scsi_pending;
    end
  end
endmodule // dsim_merge
`default_nettype wire

// ==== testbench/dsim_merge_asserts.sv ====
// Checker for the interrupt merge block.
`timescale 1ns/1ps
`default_nettype none
module dsim_merge_asserts
  import dsim_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Watched inputs.
  input wire logic [7:0] dma_cmd,
  input wire logic descriptor_list_mode,
  input wire dsim_dma_ev_t dma_ev,
  input wire logic power_down_input,
  input wire dsim_scsi_ev_t scsi_ev,
  input wire dsim_scsi_rd_t scsi_rd,
  // Watched outputs.
  input wire logic [7:0] dma_status,
  input wire logic scsi_block_irq_flag,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_done_gate: assert property ($rose(dma_status[2]) |->
    $past(dma_ev.done & dma_cmd[6], 2)) else $error("done flag without cause");
  a_page_gate: assert property ($rose(dma_status[5]) |->
    $past(dma_ev.page_done & dma_cmd[5] & descriptor_list_mode, 2)) else $error("page flag");
  a_abort_set: assert property (!$past(rst) && !$past(rst, 2) && $past(|dma_ev[3:1], 2)
    |-> dma_status[1]) else $error("abort flag missing");
  a_power_down_input_mirror: assert property (!$past(rst) |->
    dma_status[0] == $past(power_down_input)) else $error("power-down bit lag");
  a_scsi_set: assert property (!$past(rst) && $past(|scsi_ev) |->
    scsi_block_irq_flag) else $error("scsi flag missing");
  a_irq_any: assert property (|dma_status[5:1] |-> irq) else $error("irq low");
  a_irq_source: assert property ($rose(irq) |->
    $past(|{dma_ev, scsi_ev}, 2) || dma_status[0]) else $error("irq without source");
  a_scsi_clear: assert property ($fell(scsi_block_irq_flag) |->
    $past(|scsi_rd)) else $error("scsi flag cleared without read");
  cover property (irq && dma_status[4]);
  cover property ($fell(scsi_block_irq_flag));
  cover property (irq && dma_status[0]);
endmodule // dsim_merge_asserts
bind dsim_merge dsim_merge_asserts chk_u (.mclk, .rst, .dma_cmd, .descriptor_list_mode,
  .dma_ev, .power_down_input, .scsi_ev, .scsi_rd, .dma_status, .scsi_block_irq_flag, .irq);
`default_nettype wire

// ==== testbench/dsim_host_model.sv ====
// Host model that services the interrupt line.
`timescale 1ns/1ps
`default_nettype none
module dsim_host_model
  import dsim_pkg::*;
(
  // Clock and control.
  input wire logic mclk,
  input wire logic en,
  // Device outputs.
  input wire logic irq,
  input wire logic [7:0] st,
  // Host reads.
  output logic rd,
  output dsim_scsi_rd_t srd
);
  logic [2:0] step = 3'h0;
  // Status first; SCSI reads only if bit 4 is set, then three idle steps before irq is sampled again.
  always_ff @(posedge mclk) begin
    if (step == 3'h0) begin
      step <= {2'h0, en & irq};
    end else if (step == 3'h1) begin
      step <= st[4] ? 3'h2 : 3'h5;
    end else begin
      step <= step + 3'h1;
    end
  end
  assign rd = step == 3'h1;
  assign srd = {step == 3'h2, step == 3'h3, step == 3'h4};
endmodule // dsim_host_model
`default_nettype wire

// ==== testbench/test_dsim_merge.sv ====
// Self-checking bench for the interrupt merge block.
`timescale 1ns/1ps
`default_nettype none
module test_dsim_merge;
  import dsim_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] cmd = 8'h00;
  logic dlm = 1'b0;
  logic pwr = 1'b0;
  logic brd = 1'b0;
  logic en = 1'b0;
  logic go = 1'b0;
  logic hrd;
  logic sf;
  logic irq;
  logic [7:0] st;
  logic [5:0] d;
  logic [7:0] x;
  dsim_dma_ev_t dev = '0;
  dsim_scsi_ev_t sev = '0;
  dsim_scsi_rd_t srd;
  logic [9:0] exp_q[$];
  int fails = 0;
  int comparisons = 0;
  int i;
  // Half period of 25 ns gives 20 MHz.
  always #25 mclk = ~mclk;
  dsim_merge dut_u (.mclk(mclk), .rst(rst), .dma_cmd(cmd), .descriptor_list_mode(dlm),
    .dma_ev(dev), .power_down_input(pwr), .scsi_ev(sev), .scsi_rd(srd),
    .dma_status_rd(brd | hrd), .dma_status(st), .scsi_block_irq_flag(sf), .irq(irq));
  dsim_host_model host_u (.mclk(mclk), .en(en), .irq(irq), .st(st), .rd(hrd), .srd(srd));
  task automatic check(input logic [9:0] seen, input logic [9:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One-cycle pulses, then a note once both register stages have passed.
  task automatic fire(input logic [5:0] de, input logic [5:0] se, input logic r,
    input logic [9:0] want);
    dev = de;
    sev = se;
    brd = r;
    @(posedge mclk);
    #2;
    dev = '0;
    sev = '0;
    brd = 1'b0;
    @(posedge mclk);
    #2;
    exp_q.push_back(want);
    go = 1'b1;
    @(posedge mclk);
    #2;
    go = 1'b0;
  endtask
  // Takes the oldest note whenever a result is flagged.
  always @(negedge mclk) begin
    if (go && exp_q.size() > 0) begin
      check({st, sf, irq}, exp_q.pop_front());
    end
  end
  // Random DMA events, then SCSI events, then the power-down pin.
  initial begin
    void'($urandom(77));
    repeat (8) @(posedge mclk);
    #2;
    rst = 1'b0;
    for (i = 0; i < 40; i++) begin
      cmd = 8'($urandom);
      dlm = 1'($urandom);
      d = 6'($urandom);
      x = {2'h0, d[0] & cmd[5] & dlm, 1'b0, d[4] & cmd[6], d[5] & cmd[6], |d[3:1], 1'b0};
      fire(d, 6'h00, 1'($urandom), {x, 1'b0, |x});
      fire(6'h00, 6'h00, 1'b1, 10'h000);
    end
    for (i = 0; i < 6; i++) begin
      fire(6'h00, 6'h01 << i, 1'b0, {8'h10, 2'h3});
      fire(6'h00, 6'h00, 1'b1, {8'h10, 2'h3});
      en = 1'b1;
      for (int w = 0; w < 20 && irq !== 1'b0; w++) @(posedge mclk);
      #2;
      en = 1'b0;
      if (irq !== 1'b0) begin
        fails++;
        summarize();
      end
      fire(6'h00, 6'h00, 1'b0, 10'h000);
    end
    pwr = 1'b1;
    fire(6'h00, 6'h00, 1'b0, {8'h01, 2'h1});
    fire(6'h00, 6'h00, 1'b1, {8'h01, 2'h0});
    pwr = 1'b0;
    fire(6'h00, 6'h00, 1'b0, 10'h000);
    summarize();
  end
endmodule // test_dsim_merge
`default_nettype wire
